// File: shared/hrp_pkg.sv
// host register port: constants, states and carrier types
// assumes one 10 MHz system clock and a synchronous active-high reset
package hrp_pkg;

    localparam int ADDR_W = 5;
    localparam int DATA_W = 8;
    localparam int STROBE_W = 3;

    // bus style select level that picks the data-strobe style
    localparam logic STYLE_DS = 1'h1;

    // strobes idle high, so the synchroniser resets to all ones
    localparam logic [STROBE_W-1:0] STROBE_IDLE = 3'h7;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_RST = 5'h00;

    typedef enum logic [1:0] {
        HRP_IDLE = 2'b00,
        HRP_REQ = 2'b01,
        HRP_FETCH = 2'b10,
        HRP_ACK = 2'b11
    } hrp_state_type;

    // synchronised host strobes, ordered as STROBE_IDLE
    typedef struct packed {
        logic cs_n;
        logic ds_n;
        logic rw_n;
    } hrp_strobe_type;

    // request to the internal register file
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } hrp_req_type;

    // one pad driver: level and output enable
    typedef struct packed {
        logic val;
        logic oe;
    } hrp_pin_type;

    localparam hrp_pin_type PIN_FLOAT = '{val: 1'h0, oe: 1'h0};
    localparam hrp_pin_type PIN_LOW = '{val: 1'h0, oe: 1'h1};
    localparam hrp_pin_type PIN_HIGH = '{val: 1'h1, oe: 1'h1};
    localparam hrp_req_type REQ_RST = '{addr: ADDR_RST, wdata: DATA_RST, wr: 1'h0, rd: 1'h0};

endpackage : hrp_pkg

// File: design/hrp_sync.sv
// two-flop synchroniser for the host strobes
// assumes inputs may change at any time relative to sys_clk_i
`timescale 1ns/1ns
module hrp_sync #(
    parameter int WIDTH = 3,
    parameter logic [WIDTH-1:0] RST_VAL = '1
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // asynchronous in, synchronous out
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_r;

    // first stage feeds only the second stage
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            meta_r <= RST_VAL;
            sync_o <= RST_VAL;
        end else begin
            meta_r <= async_i;
            sync_o <= meta_r;
        end
    end

endmodule : hrp_sync

// File: design/hrp_port.sv
// host register port: processor-side handshake, data bus and interrupt pin
// assumes the register file answers a read one cycle after reg_req_o.rd
// assumes bus_style_select_i is strapped static
`timescale 1ns/1ns
module hrp_port (
    // clock and resets
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic chip_reset_low_i,
    // static configuration pins
    input wire logic bus_style_select_i,
    input wire logic output_float_low_i,
    // host control pins
    input wire logic register_select_low_i,
    input wire logic data_strobe_low_i,
    input wire logic read_write_low_i,
    input wire logic [hrp_pkg::ADDR_W-1:0] reg_addr_i,
    // host data bus
    input wire logic [hrp_pkg::DATA_W-1:0] data_i,
    output logic [hrp_pkg::DATA_W-1:0] data_o,
    output logic data_oe_o,
    // acknowledge / ready pin
    output logic transfer_acknowledge_low_o,
    output logic ack_oe_o,
    // interrupt pin
    output logic irq_active_low_o,
    output logic irq_oe_o,
    // pad pull-up control
    output logic pullup_enable_o,
    // internal register file side
    output hrp_pkg::hrp_req_type reg_req_o,
    input wire logic [hrp_pkg::DATA_W-1:0] reg_rdata_i,
    input wire logic irq_pending_i
);

    import hrp_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // helpers

    // acknowledge pin drive for a given state and style
    function automatic hrp_pin_type ack_drive(input hrp_state_type st, input logic ds);
        hrp_pin_type p;
        p = PIN_FLOAT;
        unique case (st)
            HRP_IDLE: p = PIN_FLOAT;
            HRP_REQ, HRP_FETCH: p = ds ? PIN_FLOAT : PIN_LOW;
            HRP_ACK: p = ds ? PIN_LOW : PIN_HIGH;
        endcase
        return p;
    endfunction : ack_drive

    // interrupt pin drive: open-drain low or push-pull high
    function automatic hrp_pin_type irq_drive(input logic pend, input logic ds);
        hrp_pin_type p;
        if (ds) begin
            p.val = 1'h0;
            p.oe = pend;
        end else begin
            p.val = pend;
            p.oe = 1'h1;
        end
        return p;
    endfunction : irq_drive

    ////////////////////////////////////////////////////////////////////////////////
    // reset and strobe synchronisation

    logic rst_int;
    logic style_ds;
    hrp_strobe_type pins_raw;
    hrp_strobe_type pins_s;
    logic io_read_strobe_low;
    logic io_write_strobe_low;
    logic cycle_on;
    logic read_now;

    assign rst_int = rst_i | ~chip_reset_low_i;
    assign style_ds = (bus_style_select_i == STYLE_DS);
    assign pins_raw = '{cs_n: register_select_low_i, ds_n: data_strobe_low_i,
                        rw_n: read_write_low_i};

    hrp_sync #(
        .WIDTH(STROBE_W),
        .RST_VAL(STROBE_IDLE)
    ) u_sync (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_int),
        .async_i(pins_raw),
        .sync_o(pins_s)
    );

    // shared pins take their strobe meaning in the io style
    assign io_read_strobe_low = pins_s.ds_n;
    assign io_write_strobe_low = pins_s.rw_n;

    // address and data are not synchronised: the host holds them stable
    // while the strobe is low, and we look on the third clock edge after the strobe falls
    assign cycle_on = ~pins_s.cs_n & (style_ds ? ~pins_s.ds_n
                      : (~io_read_strobe_low | ~io_write_strobe_low));
    assign read_now = style_ds ? pins_s.rw_n : ~io_read_strobe_low;

    ////////////////////////////////////////////////////////////////////////////////
    // access sequencer

    hrp_state_type state_r;
    hrp_state_type state_nxt;
    logic rd_r;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            HRP_IDLE: if (cycle_on) begin
                state_nxt = HRP_REQ;
            end
            HRP_REQ: state_nxt = rd_r ? HRP_FETCH : HRP_ACK;
            HRP_FETCH: state_nxt = HRP_ACK;
            // a strobe rise ends the access; no early abort mid request
            HRP_ACK: if (!cycle_on) begin
                state_nxt = HRP_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_int) begin
            state_r <= HRP_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // direction, address and write data captured at cycle start
    always_ff @(posedge sys_clk_i) begin
        if (rst_int) begin
            rd_r <= 1'h0;
            reg_req_o <= REQ_RST;
        end else begin
            reg_req_o.wr <= 1'h0;
            reg_req_o.rd <= 1'h0;
            if (state_r == HRP_IDLE && cycle_on) begin
                rd_r <= read_now;
                reg_req_o.addr <= reg_addr_i;
                reg_req_o.wdata <= data_i;
                reg_req_o.wr <= ~read_now;
                reg_req_o.rd <= read_now;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pad drivers, all registered

    hrp_pin_type ack_nxt;
    hrp_pin_type irq_nxt;

    assign ack_nxt = ack_drive(state_nxt, style_ds);
    assign irq_nxt = irq_drive(irq_pending_i, style_ds);

    always_ff @(posedge sys_clk_i) begin
        if (rst_int) begin
            transfer_acknowledge_low_o <= PIN_FLOAT.val;
            ack_oe_o <= PIN_FLOAT.oe;
        end else begin
            transfer_acknowledge_low_o <= ack_nxt.val;
            ack_oe_o <= ack_nxt.oe & output_float_low_i;
        end
    end

    // read data is loaded on the same edge that enables the bus, so it is valid on drive
    always_ff @(posedge sys_clk_i) begin
        if (rst_int) begin
            data_o <= DATA_RST;
            data_oe_o <= 1'h0;
        end else begin
            if (state_r == HRP_FETCH) begin
                data_o <= reg_rdata_i;
            end
            data_oe_o <= (state_nxt == HRP_ACK) & rd_r & output_float_low_i;
        end
    end

    // io style must show low from reset on, hence the strap-dependent enable
    always_ff @(posedge sys_clk_i) begin
        if (rst_int) begin
            irq_active_low_o <= 1'h0;
            irq_oe_o <= ~style_ds & output_float_low_i;
            pullup_enable_o <= 1'h0;
        end else begin
            irq_active_low_o <= irq_nxt.val;
            irq_oe_o <= irq_nxt.oe & output_float_low_i;
            pullup_enable_o <= output_float_low_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_int);

    ds_write_ack_a: assert property (
        (style_ds && $rose(ack_oe_o) && !rd_r) |-> $past(reg_req_o.wr) && !transfer_acknowledge_low_o
    ) else $error("write acknowledged before data capture");

    ds_read_ack_a: assert property (
        (style_ds && ack_oe_o && !transfer_acknowledge_low_o && rd_r) |-> data_oe_o
    ) else $error("read acknowledged without data on the bus");

    io_ready_low_a: assert property (
        (!style_ds && output_float_low_i && state_r == HRP_REQ && $past(state_r == HRP_IDLE))
        |-> ack_oe_o && !transfer_acknowledge_low_o
    ) else $error("ready not driven low at cycle start");

    io_ready_high_a: assert property (
        (!style_ds && ack_oe_o && transfer_acknowledge_low_o)
        |-> state_r == HRP_ACK && (!rd_r || data_oe_o)
    ) else $error("ready high before data valid or captured");

    ack_float_idle_a: assert property (
        state_r == HRP_IDLE |-> !ack_oe_o
    ) else $error("acknowledge driven outside a cycle");

    read_data_a: assert property (
        $rose(data_oe_o) |-> rd_r && data_o == $past(reg_rdata_i)
    ) else $error("data bus driven with wrong or stale data");

    data_read_only_a: assert property (
        data_oe_o |-> rd_r && state_r == HRP_ACK
    ) else $error("data bus driven outside a read");

    irq_open_drain_a: assert property (
        (style_ds && $past(style_ds) && $past(output_float_low_i) && !$past(rst_int))
        |-> irq_oe_o == $past(irq_pending_i) && !irq_active_low_o
    ) else $error("open-drain interrupt wrong");

    irq_push_pull_a: assert property (
        (!style_ds && $past(!style_ds) && $past(output_float_low_i) && !$past(rst_int))
        |-> irq_oe_o && irq_active_low_o == $past(irq_pending_i)
    ) else $error("driven interrupt wrong");

    reset_state_a: assert property (
        disable iff (1'h0) $past(rst_int) |-> state_r == HRP_IDLE && !ack_oe_o && !data_oe_o
        && !reg_req_o.wr && !reg_req_o.rd
    ) else $error("block not in reset state");

    float_all_a: assert property (
        (!$past(output_float_low_i) && !$past(rst_int))
        |-> !ack_oe_o && !data_oe_o && !irq_oe_o && !pullup_enable_o
    ) else $error("driver active while outputs floated");

    sync_delay_a: assert property (
        (state_r == HRP_REQ && $past(state_r == HRP_IDLE) && !$past(rst_int, 3))
        |-> !$past(register_select_low_i, 3)
    ) else $error("cycle started on an unsynchronised strobe");

    style_ack_a: assert property (
        (state_r == HRP_ACK && $past(output_float_low_i))
        |-> ack_oe_o && transfer_acknowledge_low_o == !style_ds
    ) else $error("acknowledge level does not match style");

    ack_length_a: assert property (
        (state_r == HRP_IDLE && cycle_on) |-> ##[2:3] state_r == HRP_ACK
    ) else $error("acknowledge not reached in time");

    ack_release_a: assert property (
        (state_r == HRP_ACK && !cycle_on) |=> !ack_oe_o && !data_oe_o
    ) else $error("drivers not released after the strobe rise");

    req_pulse_a: assert property (
        (reg_req_o.wr || reg_req_o.rd) |-> !(reg_req_o.wr && reg_req_o.rd) ##1 (!reg_req_o.wr && !reg_req_o.rd)
    ) else $error("register request not a single one-cycle pulse");

    wdata_capture_a: assert property (
        reg_req_o.wr |-> reg_req_o.wdata == $past(data_i)
    ) else $error("write data not taken from the bus");

    pullup_follow_a: assert property (
        !$past(rst_int) |-> pullup_enable_o == $past(output_float_low_i)
    ) else $error("pull-up enable does not follow the float pin");

    cover_ds_write_c: cover property (style_ds && reg_req_o.wr ##1 state_r == HRP_ACK);
    cover_ds_read_c: cover property (style_ds && $rose(data_oe_o));
    cover_io_read_c: cover property (!style_ds && $rose(data_oe_o) && transfer_acknowledge_low_o);
    cover_io_write_c: cover property (!style_ds && reg_req_o.wr ##1 transfer_acknowledge_low_o);
    cover_float_c: cover property (!output_float_low_i && state_r == HRP_ACK);

endmodule : hrp_port

// File: verification/hrp_host_model.sv
// host processor model: drives the register port strobes, address and data
// assumes the bench resolves the shared data wire and feeds it back as data_i
`timescale 1ns/1ns
module hrp_host_model (
    // clock and strap
    input wire logic sys_clk_i,
    input wire logic style_i,
    // acknowledge pin and data wire as seen by the host
    input wire logic ack_val_i,
    input wire logic ack_oe_i,
    input wire logic [hrp_pkg::DATA_W-1:0] data_i,
    // host control pins
    output logic cs_low_o,
    output logic ds_low_o,
    output logic rw_low_o,
    output logic [hrp_pkg::ADDR_W-1:0] addr_o,
    output logic [hrp_pkg::DATA_W-1:0] wdata_o,
    output logic wdrive_o
);
    initial begin
        cs_low_o = 1'h1;
        ds_low_o = 1'h1;
        rw_low_o = 1'h1;
        addr_o = '0;
        wdata_o = '0;
        wdrive_o = 1'h0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // one access; hold stretches the strobe past acknowledge (slow host)
    task automatic access(input logic rd, input logic [4:0] a, input logic [7:0] d,
                          input int hold, output logic ok, output logic [7:0] q,
                          output logic [1:0] seen);
        int n;
        ok = 1'h0;
        q = 8'h00;
        seen = 2'h0;
        @(posedge sys_clk_i);
        #10;
        addr_o = a;
        wdata_o = d;
        wdrive_o = !rd;
        rw_low_o = rd;
        ds_low_o = style_i ? 1'h0 : !rd;
        cs_low_o = 1'h0;
        for (n = 0; n < 12 && !ok; n++) begin
            @(posedge sys_clk_i);
            if (ack_oe_i && !ack_val_i) seen[1] = 1'h1;
            if (ack_oe_i && ack_val_i) seen[0] = 1'h1;
            ok = ack_oe_i && (ack_val_i != style_i);
            q = data_i;
        end
        repeat (hold) @(posedge sys_clk_i);
        #10;
        // rising strobe ends the access; address held until then
        ds_low_o = 1'h1;
        rw_low_o = 1'h1;
        cs_low_o = 1'h1;
        wdrive_o = 1'h0;
        repeat (4) @(posedge sys_clk_i);
    endtask : access
endmodule : hrp_host_model

// File: verification/hrp_port_tb.sv
// self-checking bench for the host register port, both bus styles
// assumes a register file answering reads one cycle after the read pulse
`timescale 1ns/1ns
module hrp_port_tb;
    import hrp_pkg::*;
    logic sys_clk_i, rst_i, chip_reset_low_i, bus_style_select_i, output_float_low_i;
    logic cs_l, ds_l, rw_l, wdrive, irq_pending_i, ok;
    logic data_oe_o, ack_o, ack_oe_o, irq_o, irq_oe_o, pullup_o;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, data_o, bus, q, reg_rdata_i;
    logic [DATA_W-1:0] noise_r = 8'h5a;
    logic [1:0] seen;
    logic [12:0] wr_seen;
    hrp_req_type reg_req_o;
    int miscompares = 0, samples_checked = 0, seed = 23, wr_cnt = 0, rd_cnt = 0;

    // released wire shows a changing pattern, not the last value
    always @(posedge sys_clk_i) noise_r <= ~noise_r;
    assign bus = data_oe_o ? data_o : (wdrive ? wdata : noise_r);

    function automatic logic [7:0] reg_model(input logic [4:0] a);
        return {a[2:0], a} ^ 8'h5a;
    endfunction : reg_model
    always_comb reg_rdata_i = reg_model(reg_req_o.addr);

    always @(posedge sys_clk_i) begin
        if (reg_req_o.wr === 1'h1) begin
            wr_cnt++;
            wr_seen = {reg_req_o.addr, reg_req_o.wdata};
        end
        if (reg_req_o.rd === 1'h1) rd_cnt++;
    end

    hrp_port u_hrp_port (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .chip_reset_low_i(chip_reset_low_i), .bus_style_select_i(bus_style_select_i),
        .output_float_low_i(output_float_low_i), .register_select_low_i(cs_l),
        .data_strobe_low_i(ds_l), .read_write_low_i(rw_l), .reg_addr_i(addr),
        .data_i(bus), .data_o(data_o), .data_oe_o(data_oe_o),
        .transfer_acknowledge_low_o(ack_o), .ack_oe_o(ack_oe_o), .irq_active_low_o(irq_o),
        .irq_oe_o(irq_oe_o), .pullup_enable_o(pullup_o), .reg_req_o(reg_req_o),
        .reg_rdata_i(reg_rdata_i), .irq_pending_i(irq_pending_i));
    hrp_host_model u_hrp_host_model (.sys_clk_i(sys_clk_i), .style_i(bus_style_select_i),
        .ack_val_i(ack_o), .ack_oe_i(ack_oe_o), .data_i(bus), .cs_low_o(cs_l),
        .ds_low_o(ds_l), .rw_low_o(rw_l), .addr_o(addr), .wdata_o(wdata),
        .wdrive_o(wdrive));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic complete_run;
        $display("miscompares %0d samples_checked %0d", miscompares, samples_checked);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run

    task automatic do_reset(input logic style);
        @(posedge sys_clk_i);
        #10;
        rst_i = 1'h1;
        bus_style_select_i = style;
        irq_pending_i = 1'h0;
        repeat (5) @(posedge sys_clk_i);
        #10;
        check(16'({ack_oe_o, data_oe_o, pullup_o}), 16'h0000);
        check(16'({irq_oe_o, irq_o}), 16'({!style, 1'h0}));
        rst_i = 1'h0;
        repeat (3) @(posedge sys_clk_i);
    endtask : do_reset

    task automatic run(input logic rd, input logic [4:0] a, input logic [7:0] d,
                       input int hold);
        int w0, r0;
        w0 = wr_cnt;
        r0 = rd_cnt;
        u_hrp_host_model.access(rd, a, d, hold, ok, q, seen);
        #10;
        check(16'(ok), 16'h0001);
        check(16'(seen), 16'({1'h1, !bus_style_select_i}));
        check(16'(wr_cnt - w0), 16'(!rd));
        check(16'(rd_cnt - r0), 16'(rd));
        if (rd) check(16'(q), 16'(reg_model(a)));
        else check(16'(wr_seen), 16'({a, d}));
        check(16'({ack_oe_o, data_oe_o}), 16'h0000);
    endtask : run

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk_i = 1'h0;
        forever #50 sys_clk_i = ~sys_clk_i;
    end

    // whole run is about 700 cycles; allow well over ten times that
    initial begin
        #2_000_000;
        miscompares++;
        complete_run();
    end

    initial begin
        rst_i = 1'h1;
        chip_reset_low_i = 1'h1;
        bus_style_select_i = 1'h1;
        output_float_low_i = 1'h1;
        irq_pending_i = 1'h0;
        for (int s = 1; s >= 0; s--) begin
            do_reset(s[0]);
            // back-to-back at both address ends, prompt and slow host
            run(1'h0, 5'h1f, 8'hff, 0);
            run(1'h1, 5'h1f, 8'h00, 0);
            run(1'h0, 5'h00, 8'h00, 3);
            run(1'h1, 5'h00, 8'h00, 3);
            repeat (20) begin
                irq_pending_i = 1'($random(seed));
                run(1'($random(seed)), 5'($random(seed)), 8'($random(seed)),
                    int'({$random(seed)} % 4));
                check(16'({irq_oe_o, irq_o}),
                      16'(s[0] ? {irq_pending_i, 1'h0} : {1'h1, irq_pending_i}));
            end
            // float: nothing driven, acknowledge never reaches the host
            output_float_low_i = 1'h0;
            irq_pending_i = 1'h1;
            repeat (2) @(posedge sys_clk_i);
            #10;
            check(16'({ack_oe_o, data_oe_o, irq_oe_o, pullup_o}), 16'h0000);
            u_hrp_host_model.access(1'h1, 5'h03, 8'h00, 0, ok, q, seen);
            check(16'({ok, seen}), 16'h0000);
            #10;
            output_float_low_i = 1'h1;
            // chip reset pin overrides pending interrupt and drivers
            chip_reset_low_i = 1'h0;
            repeat (3) @(posedge sys_clk_i);
            #10;
            check(16'({ack_oe_o, data_oe_o, pullup_o, irq_oe_o, irq_o}),
                  16'({3'h0, !s[0], 1'h0}));
            chip_reset_low_i = 1'h1;
            repeat (3) @(posedge sys_clk_i);
            run(1'h1, 5'h11, 8'h00, 1);
        end
        complete_run();
    end
endmodule : hrp_port_tb
